// [src/uf_fifo_ctrl.sv]
// FIFO control of one UART channel: control register, fill counters,
// trigger levels, DMA ready outputs, interrupt status.
// Assumes a 32-bit APB master on the same clock and strobes from the UART core.
`timescale 1ns/1ps
`default_nettype none
module uf_fifo_ctrl
  import uf_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST,
  input  wire logic                 CE,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [uf_pkg::UF_AW-1:0] PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic                 RX_PUSH,
  input  wire logic                 RX_POP,
  input  wire logic                 RX_TIMEOUT,
  input  wire logic                 TX_PUSH,
  input  wire logic                 TX_POP,
  output logic                      TX_DMA_READY_N,
  output logic                      RX_DMA_READY_N,
  output logic                      FIFO_EN,
  output logic                      RX_FLOW_TRIG,
  output logic                      TX_FLOW_TRIG,
  output logic      [1:0]           ISR_FIFO_BITS,
  output logic                      IRQ
);
  import uf_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0]          fc_q;
  logic [31:0]         lv_q;
  logic [UF_IRQ_W-1:0] ist_q;
  logic [UF_IRQ_W-1:0] ist_d;
  logic [UF_IRQ_W-1:0] imask_q;
  logic                en_chg_q;
  logic                rx_hit_q;
  logic                tx_low_q;
  logic                wr_acc;
  logic                rd_acc;
  logic                addr_ok;
  logic [CW-1:0]       rx_cnt;
  logic [CW-1:0]       tx_cnt;
  logic [CW-1:0]       cap;
  logic                rx_ovf;
  logic [7:0]          rx_cnt8;
  logic [7:0]          tx_cnt8;
  logic [7:0]          rx_trig;
  logic [7:0]          tx_trig;
  logic                use_lvregs;
  logic                fifo_on;
  logic                dma1;
  logic                rx_hit;
  logic                tx_low;
  logic [UF_IRQ_W-1:0] ev;
  logic [31:0]         rd_val;

  // ****************************************
  // Trigger table decode
  // ****************************************
  function automatic logic [7:0] rx_tbl(input logic [1:0] sel);
    logic [7:0] v;
    v = UF_RXT_0;
    case (sel)
      2'h1: v = UF_RXT_1;
      2'h2: v = UF_RXT_2;
      2'h3: v = UF_RXT_3;
      default: v = UF_RXT_0;
    endcase
    return v;
  endfunction : rx_tbl

  function automatic logic [7:0] tx_tbl(input logic [1:0] sel);
    logic [7:0] v;
    v = UF_TXT_0;
    case (sel)
      2'h1: v = UF_TXT_1;
      2'h2: v = UF_TXT_2;
      2'h3: v = UF_TXT_3;
      default: v = UF_TXT_0;
    endcase
    return v;
  endfunction : tx_tbl

  function automatic logic addr_is(input logic [UF_AW-1:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : addr_is

  // ****************************************
  // APB handshake: one wait state
  // ****************************************
  assign wr_acc  = PSEL && PENABLE && PREADY && PWRITE;
  assign rd_acc  = PSEL && PENABLE && !PREADY && !PWRITE;
  assign addr_ok = addr_is(PADDR, UF_OFS_FIFO_CTRL) || addr_is(PADDR, UF_OFS_LEVELS)
                || addr_is(PADDR, UF_OFS_STATUS) || addr_is(PADDR, UF_OFS_IRQ_STAT)
                || addr_is(PADDR, UF_OFS_IRQ_MASK);

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else if (CE)
    begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !addr_ok;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      PRDATA <= 32'h0000_0000;
    else if (CE && rd_acc)
      PRDATA <= rd_val;
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      fc_q     <= UF_FC_RESET;
      en_chg_q <= 1'b0;
    end
    else if (CE)
    begin
      fc_q[UF_FC_RXCLR] <= 1'b0;
      fc_q[UF_FC_TXCLR] <= 1'b0;
      en_chg_q          <= 1'b0;
      if (wr_acc && addr_is(PADDR, UF_OFS_FIFO_CTRL))
      begin
        fc_q     <= PWDATA[7:0];
        en_chg_q <= PWDATA[UF_FC_EN] != fc_q[UF_FC_EN];
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      lv_q <= UF_LV_RESET;
    else if (CE && wr_acc && addr_is(PADDR, UF_OFS_LEVELS))
      lv_q <= PWDATA;
  end

  assign fifo_on = fc_q[UF_FC_EN];
  assign dma1    = fc_q[UF_FC_DMA];

  // ****************************************
  // Fill counters
  // ****************************************
  assign cap = fifo_on ? CW'(DEPTH) : CW'(1);

  uf_fill_cnt #(
    .CW    (CW)
  ) u_rx_cnt (
    .clk   (CLK_SYS),
    .rst   (RST),
    .ce    (CE),
    .clr   (fc_q[UF_FC_RXCLR] || en_chg_q),
    .cap   (cap),
    .push  (RX_PUSH),
    .pop   (RX_POP),
    .count (rx_cnt),
    .ovf   (rx_ovf)
  );

  uf_fill_cnt #(
    .CW    (CW)
  ) u_tx_cnt (
    .clk   (CLK_SYS),
    .rst   (RST),
    .ce    (CE),
    .clr   (fc_q[UF_FC_TXCLR] || en_chg_q),
    .cap   (cap),
    .push  (TX_PUSH),
    .pop   (TX_POP),
    .count (tx_cnt),
    .ovf   ()
  );

  assign rx_cnt8 = 8'(rx_cnt);
  assign tx_cnt8 = 8'(tx_cnt);

  // ****************************************
  // Trigger levels
  // ****************************************
  assign use_lvregs = lv_q != 32'h0000_0000;

  always_comb
  begin
    if (!fifo_on)
    begin
      rx_trig = UF_SINGLE_LVL;
      tx_trig = UF_SINGLE_LVL;
    end
    else if (use_lvregs)
    begin
      rx_trig = lv_q[UF_LV_RX_LO +: 8];
      tx_trig = lv_q[UF_LV_TX_LO +: 8];
    end
    else
    begin
      rx_trig = rx_tbl(fc_q[UF_FC_RXTRIG_LO +: 2]);
      tx_trig = tx_tbl(fc_q[UF_FC_TXTRIG_LO +: 2]);
    end
  end

  assign rx_hit = rx_cnt8 >= rx_trig;
  assign tx_low = tx_cnt8 < tx_trig;

  // ****************************************
  // DMA ready outputs
  // ****************************************
  uf_rdy_gen u_tx_rdy (
    .clk      (CLK_SYS),
    .rst      (RST),
    .ce       (CE),
    .hyst     (fifo_on && dma1),
    .set_cond (tx_cnt8 <= tx_trig),
    .rel_cond (tx_cnt == CW'(DEPTH)),
    .lvl_cond (tx_cnt == '0),
    .ready_n  (TX_DMA_READY_N)
  );

  uf_rdy_gen u_rx_rdy (
    .clk      (CLK_SYS),
    .rst      (RST),
    .ce       (CE),
    .hyst     (fifo_on && dma1),
    .set_cond ((rx_hit || RX_TIMEOUT) && rx_cnt != '0),
    .rel_cond (rx_cnt == '0),
    .lvl_cond (rx_cnt != '0),
    .ready_n  (RX_DMA_READY_N)
  );

  // ****************************************
  // Flow-control levels and status outputs
  // ****************************************
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      rx_hit_q      <= 1'b0;
      tx_low_q      <= 1'b0;
      FIFO_EN       <= 1'b0;
      RX_FLOW_TRIG  <= 1'b0;
      TX_FLOW_TRIG  <= 1'b0;
      ISR_FIFO_BITS <= UF_ISR_FIFO_OFF;
    end
    else if (CE)
    begin
      rx_hit_q      <= rx_hit;
      tx_low_q      <= tx_low;
      FIFO_EN       <= fifo_on;
      RX_FLOW_TRIG  <= rx_hit;
      TX_FLOW_TRIG  <= tx_low;
      ISR_FIFO_BITS <= fifo_on ? UF_ISR_FIFO_ON : UF_ISR_FIFO_OFF;
    end
  end

  // ****************************************
  // Interrupt status, mask and output
  // ****************************************
  always_comb
  begin
    ev                = '0;
    ev[UF_IRQ_RXTRIG] = rx_hit && !rx_hit_q;
    ev[UF_IRQ_TXLOW]  = tx_low && !tx_low_q;
    ev[UF_IRQ_RXTMO]  = RX_TIMEOUT;
    ev[UF_IRQ_RXOVF]  = rx_ovf;
  end

  always_comb
  begin
    ist_d = ist_q;
    if (wr_acc && addr_is(PADDR, UF_OFS_IRQ_STAT))
      ist_d = ist_q & ~PWDATA[UF_IRQ_W-1:0];
    ist_d = ist_d | ev;
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ist_q   <= UF_IRQ_RESET;
      imask_q <= UF_IRQ_RESET;
      IRQ     <= 1'b0;
    end
    else if (CE)
    begin
      ist_q <= ist_d;
      if (wr_acc && addr_is(PADDR, UF_OFS_IRQ_MASK))
        imask_q <= PWDATA[UF_IRQ_W-1:0];
      IRQ <= |(ist_d & imask_q);
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (addr_is(PADDR, UF_OFS_FIFO_CTRL))
      rd_val[7:0] = fc_q;
    else if (addr_is(PADDR, UF_OFS_LEVELS))
      rd_val = lv_q;
    else if (addr_is(PADDR, UF_OFS_STATUS))
    begin
      rd_val[UF_ST_RXCNT_LO +: 8] = rx_cnt8;
      rd_val[UF_ST_TXCNT_LO +: 8] = tx_cnt8;
      rd_val[UF_ST_RX_DMA_READY_N]         = RX_DMA_READY_N;
      rd_val[UF_ST_TX_DMA_READY_N]         = TX_DMA_READY_N;
      rd_val[UF_ST_RXHIT]         = rx_hit;
      rd_val[UF_ST_TXBELOW]       = tx_low;
      rd_val[UF_ST_ISR_LO +: 2]   = ISR_FIFO_BITS;
    end
    else if (addr_is(PADDR, UF_OFS_IRQ_STAT))
      rd_val[UF_IRQ_W-1:0] = ist_q;
    else if (addr_is(PADDR, UF_OFS_IRQ_MASK))
      rd_val[UF_IRQ_W-1:0] = imask_q;
  end

endmodule : uf_fifo_ctrl
`default_nettype wire

// [src/uf_fill_cnt.sv]
// Fill-level counter of one FIFO (data storage lies outside this block).
// Assumes push/pop are one-cycle strobes synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module uf_fill_cnt #(
  parameter int CW = 6
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          clr,
  input  wire logic [CW-1:0] cap,
  input  wire logic          push,
  input  wire logic          pop,
  output logic      [CW-1:0] count,
  output logic               ovf
);
  logic push_ok;
  logic pop_ok;

  assign push_ok = push && (count < cap);
  assign pop_ok  = pop && (count != '0);
  assign ovf     = push && !(count < cap) && !clr;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count <= '0;
    else if (ce)
    begin
      if (clr)
        count <= '0;
      else if (push_ok && !pop_ok)
        count <= count + CW'(1);
      else if (pop_ok && !push_ok)
        count <= count - CW'(1);
    end
  end
endmodule : uf_fill_cnt
`default_nettype wire

// [src/uf_pkg.sv]
// Constants shared by the FIFO control block: register map, field positions,
// reset values and trigger-level tables.
// Assumes a 32-bit APB slave port and one system clock.
package uf_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int           UF_AW            = 8;
  localparam logic [7:0]   UF_OFS_FIFO_CTRL = 8'h00;
  localparam logic [7:0]   UF_OFS_LEVELS    = 8'h04;
  localparam logic [7:0]   UF_OFS_STATUS    = 8'h08;
  localparam logic [7:0]   UF_OFS_IRQ_STAT  = 8'h0C;
  localparam logic [7:0]   UF_OFS_IRQ_MASK  = 8'h10;

  // ****************************************
  // fifo_control fields
  // ****************************************
  localparam int           UF_FC_EN         = 0;
  localparam int           UF_FC_RXCLR      = 1;
  localparam int           UF_FC_TXCLR      = 2;
  localparam int           UF_FC_DMA        = 3;
  localparam int           UF_FC_TXTRIG_LO  = 4;
  localparam int           UF_FC_RXTRIG_LO  = 6;
  localparam logic [7:0]   UF_FC_RESET      = 8'h00;

  // ****************************************
  // Level register fields and reset
  // ****************************************
  localparam int           UF_LV_RX_LO      = 0;
  localparam int           UF_LV_TX_LO      = 8;
  localparam int           UF_LV_FH_LO      = 16;
  localparam int           UF_LV_FL_LO      = 24;
  localparam logic [31:0]  UF_LV_RESET      = 32'h0000_0000;

  // ****************************************
  // Status register fields
  // ****************************************
  localparam int           UF_ST_RXCNT_LO   = 0;
  localparam int           UF_ST_TXCNT_LO   = 8;
  localparam int           UF_ST_RX_DMA_READY_N      = 16;
  localparam int           UF_ST_TX_DMA_READY_N      = 17;
  localparam int           UF_ST_RXHIT      = 18;
  localparam int           UF_ST_TXBELOW    = 19;
  localparam int           UF_ST_ISR_LO     = 24;

  // ****************************************
  // Interrupt status bits
  // ****************************************
  localparam int           UF_IRQ_W         = 4;
  localparam int           UF_IRQ_RXTRIG    = 0;
  localparam int           UF_IRQ_TXLOW     = 1;
  localparam int           UF_IRQ_RXTMO     = 2;
  localparam int           UF_IRQ_RXOVF     = 3;
  localparam logic [3:0]   UF_IRQ_RESET     = 4'h0;

  // ****************************************
  // Trigger-level tables, 32-byte mode
  // ****************************************
  localparam logic [7:0]   UF_RXT_0         = 8'h08;
  localparam logic [7:0]   UF_RXT_1         = 8'h10;
  localparam logic [7:0]   UF_RXT_2         = 8'h18;
  localparam logic [7:0]   UF_RXT_3         = 8'h1C;
  localparam logic [7:0]   UF_TXT_0         = 8'h10;
  localparam logic [7:0]   UF_TXT_1         = 8'h08;
  localparam logic [7:0]   UF_TXT_2         = 8'h18;
  localparam logic [7:0]   UF_TXT_3         = 8'h1E;
  localparam logic [7:0]   UF_SINGLE_LVL    = 8'h01;

  // ****************************************
  // Misc reset values
  // ****************************************
  localparam logic         UF_RDY_N_RESET   = 1'b1;
  localparam logic [1:0]   UF_ISR_FIFO_ON   = 2'b11;
  localparam logic [1:0]   UF_ISR_FIFO_OFF  = 2'b00;

endpackage : uf_pkg

// [src/uf_rdy_gen.sv]
// Active-low DMA ready flag with level mode and set/release hysteresis mode.
// Assumes conditions are computed from current counter values.
`timescale 1ns/1ps
`default_nettype none
module uf_rdy_gen
  import uf_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic hyst,
  input  wire logic set_cond,
  input  wire logic rel_cond,
  input  wire logic lvl_cond,
  output logic      ready_n
);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ready_n <= UF_RDY_N_RESET;
    else if (ce)
    begin
      if (!hyst)
        ready_n <= !lvl_cond;
      else if (set_cond)
        ready_n <= 1'b0;
      else if (rel_cond)
        ready_n <= 1'b1;
    end
  end
endmodule : uf_rdy_gen
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the FIFO control block.
// Assumes the host model drives the host side strobes.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import uf_pkg::*;
  logic        clk, rst, ce, psel, pen, pwr, pready, pslverr, re;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [2:0]  cs;
  logic        rx_pop, tx_push, txr_n, rxr_n, fen, rxft, txft, irq;
  logic [1:0]  interrupt_source_reg;
  int          error_cnt, checks_done;
  uf_fifo_ctrl i_uf_fifo_ctrl (
    .CLK_SYS(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_PUSH(cs[0]), .RX_POP(rx_pop), .RX_TIMEOUT(cs[2]), .TX_PUSH(tx_push), .TX_POP(cs[1]),
    .TX_DMA_READY_N(txr_n), .RX_DMA_READY_N(rxr_n), .FIFO_EN(fen), .RX_FLOW_TRIG(rxft),
    .TX_FLOW_TRIG(txft), .ISR_FIFO_BITS(interrupt_source_reg), .IRQ(irq));
  uf_host_model i_uf_host_model (.clk(clk), .rd_pop(rx_pop), .wr_push(tx_push));
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Waits for the slave's answer with no cycle limit; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'h1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'h1);
    rq = prdata;
    re = pslverr;
    psel <= 1'h0;
    pen  <= 1'h0;
    @(posedge clk);
  endtask : apb
  // Core strobes: 0 rx store, 1 tx take, 2 rx time-out
  task automatic core(input int i, input int n);
    repeat (n)
    begin
      cs[i] <= 1'h1;
      @(posedge clk);
      cs[i] <= 1'h0;
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask : core
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk("fen", 1'h0, fen);
    chk("txr_n", 1'h0, txr_n);
    chk("rxr_n", 1'h1, rxr_n);
    chk("isr", 2'h0, interrupt_source_reg);
    apb(0, UF_OFS_FIFO_CTRL, 32'h0);
    chk("fc", 32'h0, rq);
    apb(0, UF_OFS_LEVELS, 32'h0);
    chk("lv", 32'h0, rq);
  endtask : t_reset
  task automatic t_nofifo;
    core(0, 2);
    chk("rxr_n", 1'h0, rxr_n);
    apb(0, UF_OFS_STATUS, 32'h0);
    chk("rxcnt", 8'h01, rq[7:0]);
    i_uf_host_model.move(0, 1, 1);
    chk("rxr_n", 1'h1, rxr_n);
    i_uf_host_model.move(1, 1, 4);
    chk("txr_n", 1'h1, txr_n);
    core(1, 1);
    chk("txr_n", 1'h0, txr_n);
  endtask : t_nofifo
  task automatic t_rxtrig;
    int t[4] = '{8, 16, 24, 28};
    for (int k = 0; k < 4; k++)
    begin
      apb(1, UF_OFS_FIFO_CTRL, 32'h03 | 32'(k << 6));
      core(0, t[k] - 1);
      chk("rxft", 1'h0, rxft);
      chk("rxr_n", 1'h0, rxr_n);
      core(0, 1);
      chk("rxft", 1'h1, rxft);
    end
    apb(1, UF_OFS_FIFO_CTRL, 32'h03);
    apb(0, UF_OFS_FIFO_CTRL, 32'h0);
    chk("fc", 32'h01, rq);
    chk("rxft", 1'h0, rxft);
    chk("isr", 2'h3, interrupt_source_reg);
    chk("fen", 1'h1, fen);
  endtask : t_rxtrig
  task automatic t_txtrig;
    int t[4] = '{16, 8, 24, 30};
    for (int k = 0; k < 4; k++)
    begin
      apb(1, UF_OFS_FIFO_CTRL, 32'h05 | 32'(k << 4));
      i_uf_host_model.move(1, t[k], 1);
      chk("txft", 1'h0, txft);
      core(1, 1);
      chk("txft", 1'h1, txft);
    end
    apb(1, UF_OFS_FIFO_CTRL, 32'h05);
    apb(0, UF_OFS_STATUS, 32'h0);
    chk("txcnt", 8'h00, rq[15:8]);
    chk("txr_n", 1'h0, txr_n);
  endtask : t_txtrig
  task automatic t_mode1;
    apb(1, UF_OFS_FIFO_CTRL, 32'h0F);
    core(0, 7);
    chk("rxr_n", 1'h1, rxr_n);
    core(0, 1);
    chk("rxr_n", 1'h0, rxr_n);
    core(0, 4);
    apb(0, UF_OFS_STATUS, 32'h0);
    chk("rxcnt", 8'h0C, rq[7:0]);
    i_uf_host_model.move(0, 11, 1);
    chk("rxr_n", 1'h0, rxr_n);
    i_uf_host_model.move(0, 1, 1);
    chk("rxr_n", 1'h1, rxr_n);
    core(0, 1);
    core(2, 1);
    chk("rxr_n", 1'h0, rxr_n);
    i_uf_host_model.move(0, 1, 1);
    i_uf_host_model.move(1, 31, 1);
    chk("txr_n", 1'h0, txr_n);
    i_uf_host_model.move(1, 1, 4);
    chk("txr_n", 1'h1, txr_n);
    core(1, 15);
    chk("txr_n", 1'h1, txr_n);
    core(1, 1);
    chk("txr_n", 1'h0, txr_n);
  endtask : t_mode1
  task automatic t_levels;
    apb(1, UF_OFS_FIFO_CTRL, 32'h07);
    apb(1, UF_OFS_LEVELS, 32'h03);
    core(0, 2);
    chk("rxft", 1'h0, rxft);
    core(0, 1);
    chk("rxft", 1'h1, rxft);
    chk("txft", 1'h0, txft);
    // Only the flow byte nonzero: both triggers still come from the level bytes
    apb(1, UF_OFS_LEVELS, 32'h0100_0000);
    repeat (2) @(posedge clk);
    chk("txft", 1'h0, txft);
    apb(1, UF_OFS_LEVELS, 32'h0);
  endtask : t_levels
  task automatic t_irq;
    apb(1, UF_OFS_IRQ_STAT, 32'h0F);
    apb(1, UF_OFS_FIFO_CTRL, 32'h03);
    apb(1, UF_OFS_IRQ_MASK, 32'h01);
    chk("irq", 1'h0, irq);
    core(0, 8);
    chk("irq", 1'h1, irq);
    apb(0, UF_OFS_IRQ_STAT, 32'h0);
    chk("ist", 32'h01, rq);
    apb(1, UF_OFS_IRQ_STAT, 32'h01);
    chk("irq", 1'h0, irq);
    apb(0, 8'h40, 32'h0);
    chk("slverr", 1'h1, re);
    // Empty the receive side, then push while the clock enable is low
    apb(1, UF_OFS_FIFO_CTRL, 32'h03);
    ce <= 1'h0;
    core(0, 1);
    ce <= 1'h1;
    @(posedge clk);
    apb(0, UF_OFS_STATUS, 32'h0);
    chk("rxcnt", 8'h00, rq[7:0]);
    chk("rxr_n", 1'h1, rxr_n);
  endtask : t_irq
  task automatic give_verdict;
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    rst    = 1'h1;
    ce     = 1'h1;
    psel   = 1'h0;
    pen    = 1'h0;
    pwr    = 1'h0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    cs     = 3'h0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    t_reset();
    t_nofifo();
    t_rxtrig();
    t_txtrig();
    t_mode1();
    t_levels();
    t_irq();
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// [test/uf_fifo_ctrl_properties.sv]
// Concurrent checks on the ports of the FIFO control block.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module uf_fifo_ctrl_chk #(
  parameter int DEPTH = 32
) (
  input wire logic       CLK_SYS,
  input wire logic       RST,
  input wire logic       CE,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PREADY,
  input wire logic       PSLVERR,
  input wire logic       RX_PUSH,
  input wire logic       RX_POP,
  input wire logic       TX_PUSH,
  input wire logic       TX_POP,
  input wire logic       TX_DMA_READY_N,
  input wire logic       RX_DMA_READY_N,
  input wire logic       FIFO_EN,
  input wire logic       RX_FLOW_TRIG,
  input wire logic       TX_FLOW_TRIG,
  input wire logic [1:0] ISR_FIFO_BITS,
  input wire logic       IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Cycles since the FIFOs were last on, saturating
  logic [2:0] off_q;
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
      off_q <= 3'h7;
    else if (FIFO_EN)
      off_q <= 3'h0;
    else if (off_q != 3'h7)
      off_q <= off_q + 3'h1;
  property p_ans;
    PREADY && $past(CE) |-> PSEL && PENABLE && $past(PSEL && PENABLE);
  endproperty
  property p_pulse;
    PREADY && CE |=> !PREADY;
  endproperty
  property p_err;
    PSLVERR |-> PREADY;
  endproperty
  property p_isr;
    FIFO_EN == $past(FIFO_EN) |-> ISR_FIFO_BITS == {2{FIFO_EN}};
  endproperty
  property p_rx0;
    !FIFO_EN && CE && RX_PUSH && !RX_POP ##1 !FIFO_EN && CE |=> !RX_DMA_READY_N;
  endproperty
  property p_tx0;
    !FIFO_EN && CE && TX_POP && !TX_PUSH ##1 !FIFO_EN && CE |=> !TX_DMA_READY_N;
  endproperty
  property p_rxf;
    off_q == 3'h7 && !FIFO_EN |-> RX_FLOW_TRIG == !RX_DMA_READY_N;
  endproperty
  property p_txf;
    off_q == 3'h7 && !FIFO_EN |-> TX_FLOW_TRIG == !TX_DMA_READY_N;
  endproperty
  property p_ce;
    !CE |=> $stable(RX_DMA_READY_N) && $stable(TX_DMA_READY_N) && $stable(IRQ) && $stable(PREADY);
  endproperty
  a_ans: assert property (p_ans) else $error("ready outside access phase");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("error without ready");
  a_isr: assert property (p_isr) else $error("fifo bits wrong");
  a_rx0: assert property (p_rx0) else $error("rx ready missed");
  a_tx0: assert property (p_tx0) else $error("tx ready missed");
  a_rxf: assert property (p_rxf) else $error("rx trigger off");
  a_txf: assert property (p_txf) else $error("tx trigger off");
  a_ce: assert property (p_ce) else $error("moved while held");
  c_err: cover property (PSLVERR);
  c_m1: cover property (FIFO_EN && $fell(RX_DMA_READY_N));
  c_irq: cover property ($rose(IRQ));
endmodule : uf_fifo_ctrl_chk
bind uf_fifo_ctrl uf_fifo_ctrl_chk #(.DEPTH(DEPTH)) i_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_PUSH(RX_PUSH), .RX_POP(RX_POP),
  .TX_PUSH(TX_PUSH), .TX_POP(TX_POP), .TX_DMA_READY_N(TX_DMA_READY_N),
  .RX_DMA_READY_N(RX_DMA_READY_N), .FIFO_EN(FIFO_EN), .RX_FLOW_TRIG(RX_FLOW_TRIG),
  .TX_FLOW_TRIG(TX_FLOW_TRIG), .ISR_FIFO_BITS(ISR_FIFO_BITS), .IRQ(IRQ));
`default_nettype wire

// [test/uf_host_model.sv]
// Host side model: takes received and gives transmit characters.
// Assumes calls start just after a rising edge; gap is at least one.
`timescale 1ns/1ps
`default_nettype none
module uf_host_model (
  input  wire logic clk,
  output logic      rd_pop,
  output logic      wr_push
);
  initial
  begin
    rd_pop  = 1'h0;
    wr_push = 1'h0;
  end
  // One-cycle strobes, gap sets a prompt or slow host
  task automatic move(input bit tx, input int n, input int gap);
    repeat (n)
    begin
      if (tx)
        wr_push <= 1'h1;
      else
        rd_pop <= 1'h1;
      @(posedge clk);
      wr_push <= 1'h0;
      rd_pop  <= 1'h0;
      repeat (gap) @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask : move
endmodule : uf_host_model
`default_nettype wire
